// >>> common/power_mode_defs.svh
`ifndef POWER_MODE_DEFS_SVH
`define POWER_MODE_DEFS_SVH

// Reset values
`define PPD_FLAG_RST   1'b0
`define PIN_HOLD_RST   1'b0

`endif

// >>> common/power_mode_pkg.sv
package power_mode_pkg;

  typedef enum logic [2:0] {
    MODE_RESET,
    MODE_RUN,
    MODE_BACKGROUND,
    MODE_WAIT,
    MODE_LIGHT_STOP,
    MODE_DEEP_STOP
  } op_mode_e;

  typedef enum logic [2:0] {
    CMD_MEMORY,
    CMD_MEMORY_STATUS,
    CMD_DEBUG_REG,
    CMD_HALT,
    CMD_CPU_REG,
    CMD_TRACE,
    CMD_RESUME
  } debug_cmd_e;

endpackage : power_mode_pkg

// >>> core/power_mode_controller.sv
// Contract
// RULE1: Leaving reset with mode pin high enters run mode at reset vector.
// RULE2: Pin low at reset, halt command, instruction or breakpoint enter background; code samples the pin only on power-on or debug forced reset.
// RULE3: In background mode the CPU is suspended, serving only debug commands.
// RULE4: Non-intrusive debug commands accepted in run and background mode.
// RULE5: CPU register, trace, resume commands only in background mode.
// RULE6: Wait gates CPU clock, clears interrupt mask; any interrupt ends wait.
// RULE7: In wait or stop only halt and status commands; status reports error.
// RULE8: Halt command during wait wakes into background mode.
// RULE9: Stop with stop enable clear causes illegal-opcode reset.
// RULE10: Stop selects light or deep stop from debug, low-voltage and powerdown bits.
// RULE11: Any stop halts bus, CPU and peripheral clocks, even with debug clocks.
// RULE12: Light stop preserves registers, RAM and pin states.
// RULE13: Light stop ends on reset pin or listed interrupt sources.
// RULE14: Software keeps low-voltage detector enabled when analog blocks need stop operation.
// RULE15: Debug enabled at stop keeps debug clock and regulator in full regulation.
// RULE16: Debug enabled, halt command in stop wakes into background; all commands then.
// RULE17: Deep stop latches pin controls and powers down all but RAM.
// RULE18: Deep stop ends only on reset pin or enabled counter wake; acts as power-on.
// RULE19: Deep stop wake sets powerdown flag; flag and latches hold until ack written.
// RULE20: Ack opens pin latches so pins follow current port or peripheral control.
// RULE21: Light stop keeps reference clocks only when enable and stop-enable both set.
// RULE22: Stop option bits sampled at stop instruction, held until wake or reset.
`include "power_mode_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module power_mode_controller (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  // Pins
  input  wire logic                      modeSelectPin,
  input  wire logic                      resetPinLow,
  // Reset cause
  input  wire logic                      powerOnReset,
  input  wire logic                      debugForceReset,
  // CPU instruction events
  input  wire logic                      waitInstr,
  input  wire logic                      stopInstr,
  input  wire logic                      backgroundInstr,
  input  wire logic                      debugCtrlBreak,
  input  wire logic                      debugModuleBreak,
  // Option bits
  input  wire logic                      stopEnableBit,
  input  wire logic                      debugModeEnable,
  input  wire logic                      lowVoltageEnable,
  input  wire logic                      lowVoltageStopEnable,
  input  wire logic                      partialPowerdownControl,
  input  wire logic                      internalRefClockEnable,
  input  wire logic                      internalRefStopEnable,
  input  wire logic                      externalRefClockEnable,
  input  wire logic                      externalRefStopEnable,
  // Wake sources
  input  wire logic                      irqAny,
  input  wire logic                      lightStopWakeIrq,
  input  wire logic                      rtcWake,
  input  wire logic                      rtcWakeEnable,
  input  wire logic                      partialPowerdownAck,
  // Debug command
  input  wire logic                      debugCmdValid,
  input  wire power_mode_pkg::debug_cmd_e debugCmd,
  // Debug answers
  output logic                           debugCmdAccept,
  output logic                           debugCmdStatusErr,
  // Mode and clocks
  output power_mode_pkg::op_mode_e       opMode,
  output logic                           cpuClkEn,
  output logic                           busClkEn,
  output logic                           periphClkEn,
  output logic                           debugClkEn,
  output logic                           regulatorFull,
  output logic                           internalRefRun,
  output logic                           externalRefRun,
  output logic                           coreDomainPowerOn,
  // CPU control
  output logic                           cpuSuspended,
  output logic                           clearIrqMask,
  output logic                           startStacking,
  output logic                           fetchResetVector,
  output logic                           illegalOpReset,
  output logic                           deepStopPorReset,
  // Pin latch
  output logic                           pinLatchHold,
  output logic                           partialPowerdownFlag
);
  import power_mode_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic     modeSync1;
    logic     modeSync2;
    logic     rstSync1;
    logic     rstSync2;
    op_mode_e mode;
    logic     keepDebug;
    logic     keepRegulator;
    logic     keepIntRef;
    logic     keepExtRef;
    logic     ppdFlag;
    logic     pinHold;
    logic     vectorFetch;
    logic     illegalReset;
    logic     porReset;
    logic     stacking;
    logic     maskClear;
    logic     cmdAccept;
    logic     cmdStatusErr;
  } state_s;

  state_s stateReg;
  state_s stateNext;

  function automatic logic cmdAllowed(input op_mode_e m, input debug_cmd_e c);
    logic nonIntrusive;
    nonIntrusive = (c == CMD_MEMORY) || (c == CMD_MEMORY_STATUS) ||
                   (c == CMD_DEBUG_REG) || (c == CMD_HALT);
    case (m)
      MODE_RUN:        cmdAllowed = nonIntrusive; // RULE4 RULE5
      MODE_BACKGROUND: cmdAllowed = 1'b1; // RULE4 RULE5 RULE16
      MODE_WAIT,
      MODE_LIGHT_STOP: cmdAllowed = (c == CMD_HALT) || (c == CMD_MEMORY_STATUS); // RULE7
      default:         cmdAllowed = 1'b0;
    endcase
  endfunction : cmdAllowed

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic halt;
    logic enterBg;
    halt = 1'b0;
    enterBg = 1'b0;
    stateNext = stateReg;
    stateNext.modeSync1 = modeSelectPin;
    stateNext.modeSync2 = stateReg.modeSync1;
    stateNext.rstSync1 = resetPinLow;
    stateNext.rstSync2 = stateReg.rstSync1;
    stateNext.vectorFetch = 1'b0;
    stateNext.illegalReset = 1'b0;
    stateNext.porReset = 1'b0;
    stateNext.stacking = 1'b0;
    stateNext.maskClear = 1'b0;
    stateNext.cmdAccept = debugCmdValid && cmdAllowed(stateReg.mode, debugCmd);
    stateNext.cmdStatusErr = debugCmdValid && (debugCmd == CMD_MEMORY_STATUS) &&
                             ((stateReg.mode == MODE_WAIT) ||
                              (stateReg.mode == MODE_LIGHT_STOP)); // RULE7
    halt = debugCmdValid && (debugCmd == CMD_HALT) && cmdAllowed(stateReg.mode, debugCmd);
    // Ack ignored in deep stop so the pin latches cannot open there
    if (stateReg.ppdFlag && partialPowerdownAck && (stateReg.mode != MODE_DEEP_STOP)) begin
      stateNext.ppdFlag = 1'b0; // RULE19
      stateNext.pinHold = 1'b0; // RULE20
    end
    case (stateReg.mode)
      MODE_RESET: begin
        if (powerOnReset || debugForceReset) begin
          stateNext.mode = stateReg.modeSync2 ? MODE_RUN : MODE_BACKGROUND; // RULE1 RULE2
        end else begin
          stateNext.mode = MODE_RUN; // RULE1
        end
        stateNext.vectorFetch = 1'b1; // RULE1
      end
      MODE_RUN: begin
        enterBg = halt || backgroundInstr || debugCtrlBreak || debugModuleBreak; // RULE2
        if (enterBg) begin
          stateNext.mode = MODE_BACKGROUND; // RULE2
        end else if (waitInstr) begin
          stateNext.mode = MODE_WAIT; // RULE6
          stateNext.maskClear = 1'b1; // RULE6
        end else if (stopInstr && !stopEnableBit) begin
          stateNext.mode = MODE_RESET; // RULE9
          stateNext.illegalReset = 1'b1; // RULE9
        end else if (stopInstr) begin
          stateNext.keepDebug = debugModeEnable; // RULE22 RULE15
          stateNext.keepRegulator = debugModeEnable ||
                                    (lowVoltageEnable && lowVoltageStopEnable); // RULE15
          stateNext.keepIntRef = internalRefClockEnable && internalRefStopEnable; // RULE21
          stateNext.keepExtRef = externalRefClockEnable && externalRefStopEnable; // RULE21
          if (debugModeEnable || (lowVoltageEnable && lowVoltageStopEnable) ||
              !partialPowerdownControl) begin
            stateNext.mode = MODE_LIGHT_STOP; // RULE10
          end else begin
            stateNext.mode = MODE_DEEP_STOP; // RULE10
            stateNext.pinHold = 1'b1; // RULE17
          end
        end
      end
      MODE_BACKGROUND: begin
        if (debugCmdValid && (debugCmd == CMD_RESUME)) begin
          stateNext.mode = MODE_RUN; // RULE5
        end
      end
      MODE_WAIT: begin
        if (halt) begin
          stateNext.mode = MODE_BACKGROUND; // RULE8
        end else if (irqAny) begin
          stateNext.mode = MODE_RUN; // RULE6
          stateNext.stacking = 1'b1; // RULE6
        end
      end
      MODE_LIGHT_STOP: begin
        if (halt && stateReg.keepDebug) begin
          stateNext.mode = MODE_BACKGROUND; // RULE16
        end else if (lightStopWakeIrq) begin
          stateNext.mode = MODE_RUN; // RULE13
          stateNext.stacking = 1'b1; // RULE13
        end
      end
      MODE_DEEP_STOP: begin
        if (rtcWake && rtcWakeEnable) begin
          stateNext.mode = MODE_RESET; // RULE18
          stateNext.porReset = 1'b1; // RULE18
          stateNext.ppdFlag = 1'b1; // RULE19
        end
      end
      default: stateNext.mode = MODE_RESET;
    endcase
    if (stateReg.rstSync2) begin
      stateNext.mode = MODE_RESET; // RULE13 RULE18
      stateNext.vectorFetch = 1'b0; // RULE1
      if (stateReg.mode == MODE_DEEP_STOP) begin
        stateNext.porReset = 1'b1; // RULE18
        stateNext.ppdFlag = 1'b1; // RULE19
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stateReg <= '{modeSync1: 1'b1, modeSync2: 1'b1, rstSync1: 1'b0, rstSync2: 1'b0,
                    mode: MODE_RESET, ppdFlag: `PPD_FLAG_RST, pinHold: `PIN_HOLD_RST,
                    default: 1'b0};
    end else begin
      stateReg <= stateNext;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  logic inStop;
  assign inStop = (stateReg.mode == MODE_LIGHT_STOP) || (stateReg.mode == MODE_DEEP_STOP);

  assign opMode            = stateReg.mode;
  assign cpuClkEn          = (stateReg.mode == MODE_RUN) || (stateReg.mode == MODE_BACKGROUND); // RULE6 RULE11
  assign busClkEn          = !inStop; // RULE11
  assign periphClkEn       = !inStop; // RULE11 RULE12
  assign debugClkEn        = !inStop || stateReg.keepDebug; // RULE15
  assign regulatorFull     = !inStop || (stateReg.mode == MODE_LIGHT_STOP && stateReg.keepRegulator);
  assign internalRefRun    = !inStop || (stateReg.mode == MODE_LIGHT_STOP && stateReg.keepIntRef);
  assign externalRefRun    = !inStop || (stateReg.mode == MODE_LIGHT_STOP && stateReg.keepExtRef);
  assign coreDomainPowerOn = stateReg.mode != MODE_DEEP_STOP; // RULE17
  assign cpuSuspended      = stateReg.mode != MODE_RUN; // RULE3
  assign clearIrqMask      = stateReg.maskClear;
  assign startStacking     = stateReg.stacking;
  assign fetchResetVector  = stateReg.vectorFetch;
  assign illegalOpReset    = stateReg.illegalReset;
  assign deepStopPorReset  = stateReg.porReset;
  assign pinLatchHold      = stateReg.pinHold;
  assign partialPowerdownFlag = stateReg.ppdFlag;
  assign debugCmdAccept    = stateReg.cmdAccept;
  assign debugCmdStatusErr = stateReg.cmdStatusErr;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  illegal_stop_reset_a: assert property ((stateReg.mode == MODE_RUN) && stopInstr && !stopEnableBit &&
      !waitInstr && !backgroundInstr && !debugCtrlBreak && !debugModuleBreak && !debugCmdValid &&
      !stateReg.rstSync2 |=> illegalOpReset && opMode == MODE_RESET) // RULE9
    else $error("stop with stop enable clear did not reset");
  stop_clock_halt_a: assert property (inStop |-> !busClkEn && !cpuClkEn && !periphClkEn) // RULE11
    else $error("clocks running in stop");
  deep_select_a: assert property ((stateReg.mode == MODE_RUN) && stopInstr && stopEnableBit &&
      !debugModeEnable && !lowVoltageEnable && partialPowerdownControl && !waitInstr &&
      !backgroundInstr && !debugCtrlBreak && !debugModuleBreak && !debugCmdValid &&
      !stateReg.rstSync2 |=> opMode == MODE_DEEP_STOP && pinLatchHold) // RULE10
    else $error("deep stop not selected");
  debug_stop_a: assert property ((stateReg.mode == MODE_RUN) && stopInstr && stopEnableBit &&
      debugModeEnable && !waitInstr && !backgroundInstr && !debugCtrlBreak && !debugModuleBreak &&
      !debugCmdValid && !stateReg.rstSync2 |=> opMode == MODE_LIGHT_STOP && debugClkEn && regulatorFull) // RULE15
    else $error("debug clocks not kept in stop");
  wait_halt_bg_a: assert property ((stateReg.mode == MODE_WAIT) && debugCmdValid && debugCmd == CMD_HALT &&
      !stateReg.rstSync2 |=> opMode == MODE_BACKGROUND) // RULE8
    else $error("halt in wait did not enter background");
  wait_cmd_filter_a: assert property ((stateReg.mode == MODE_WAIT) && debugCmdValid &&
      debugCmd == CMD_MEMORY |=> !debugCmdAccept) // RULE7
    else $error("memory command accepted in wait");
  status_error_a: assert property ((stateReg.mode == MODE_LIGHT_STOP) && debugCmdValid &&
      debugCmd == CMD_MEMORY_STATUS |=> debugCmdStatusErr && debugCmdAccept) // RULE7
    else $error("status command gave no error in stop");
  run_cmd_filter_a: assert property ((stateReg.mode == MODE_RUN) && debugCmdValid &&
      debugCmd == CMD_TRACE |=> !debugCmdAccept) // RULE5
    else $error("trace accepted in run");
  ppd_hold_a: assert property (partialPowerdownFlag && !partialPowerdownAck && !stateReg.rstSync2
      |=> partialPowerdownFlag && pinLatchHold) // RULE19
    else $error("powerdown flag dropped without ack");
  bg_suspend_a: assert property (opMode == MODE_BACKGROUND |-> cpuSuspended) // RULE3
    else $error("CPU runs in background mode");

  wait_cover_c:  cover property ((stateReg.mode == MODE_WAIT) ##1 startStacking);
  light_cover_c: cover property ((stateReg.mode == MODE_LIGHT_STOP) ##1 opMode == MODE_RUN);
  deep_cover_c:  cover property ((stateReg.mode == MODE_DEEP_STOP) ##1 deepStopPorReset);
  ack_cover_c:   cover property (partialPowerdownFlag ##1 !partialPowerdownFlag);

endmodule : power_mode_controller

`default_nettype wire

// >>> tb/debug_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module debug_host_model (
  // Clock and mode seen by the host
  input  wire logic                  clk,
  input  wire power_mode_pkg::op_mode_e opMode,
  // Command lines
  output logic                       debugCmdValid,
  output power_mode_pkg::debug_cmd_e debugCmd
);
  import power_mode_pkg::*;

  initial begin
    debugCmdValid = 1'b0;
    debugCmd      = CMD_MEMORY;
  end

  // One-cycle command; lines scrambled while idle
  task automatic send(input debug_cmd_e c, input logic rude);
    if (!rude && c >= CMD_CPU_REG && opMode !== MODE_BACKGROUND) return;
    @(negedge clk);
    debugCmdValid = 1'b1;
    debugCmd      = c;
    @(negedge clk);
    debugCmdValid = 1'b0;
    debugCmd      = debug_cmd_e'(~c);
  endtask : send
endmodule : debug_host_model
`default_nettype wire

// >>> tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import power_mode_pkg::*;
  // ------
  // Signals
  // ------
  logic       clk, rst_n, waitInstr, stopInstr, backgroundInstr, debugCtrlBreak;
  logic       debugModuleBreak, stopEnableBit, debugModeEnable, lowVoltageEnable;
  logic       lowVoltageStopEnable, partialPowerdownControl, internalRefClockEnable;
  logic       internalRefStopEnable, externalRefClockEnable, externalRefStopEnable;
  logic       irqAny, lightStopWakeIrq, rtcWake, rtcWakeEnable, partialPowerdownAck;
  logic       debugCmdValid, debugCmdAccept, debugCmdStatusErr, cpuClkEn, busClkEn;
  logic       periphClkEn, debugClkEn, regulatorFull, internalRefRun, externalRefRun;
  logic       coreDomainPowerOn, cpuSuspended, clearIrqMask, startStacking;
  logic       fetchResetVector, illegalOpReset, deepStopPorReset, pinLatchHold;
  logic       partialPowerdownFlag;
  logic       modeSelectPin, resetPinLow, powerOnReset, debugForceReset;
  logic [8:0] v;
  debug_cmd_e debugCmd, c;
  op_mode_e   opMode, m;
  int         failures, cmp_count, cycles;
  logic [8:0] corner [6] = '{9'h000, 9'h180, 9'h160, 9'h100, 9'h110, 9'h1FF};

  power_mode_controller dut_u (
    .clk, .rst_n, .modeSelectPin, .resetPinLow, .powerOnReset,
    .debugForceReset, .waitInstr, .stopInstr, .backgroundInstr, .debugCtrlBreak,
    .debugModuleBreak, .stopEnableBit, .debugModeEnable, .lowVoltageEnable,
    .lowVoltageStopEnable, .partialPowerdownControl, .internalRefClockEnable,
    .internalRefStopEnable, .externalRefClockEnable, .externalRefStopEnable, .irqAny,
    .lightStopWakeIrq, .rtcWake, .rtcWakeEnable, .partialPowerdownAck, .debugCmdValid,
    .debugCmd, .debugCmdAccept, .debugCmdStatusErr, .opMode, .cpuClkEn, .busClkEn,
    .periphClkEn, .debugClkEn, .regulatorFull, .internalRefRun, .externalRefRun,
    .coreDomainPowerOn, .cpuSuspended, .clearIrqMask, .startStacking, .fetchResetVector,
    .illegalOpReset, .deepStopPorReset, .pinLatchHold, .partialPowerdownFlag
  );

  debug_host_model host_u (.clk, .opMode, .debugCmdValid, .debugCmd);

  always #50 clk = ~clk;

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      end_sim();
    end
  end
  // ------
  // Helpers
  // ------
  task automatic chk_mode(input op_mode_e exp);
    cmp_count++;
    if (opMode !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, opMode, exp);
    end
  endtask : chk_mode

  task automatic chk_bit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bit

  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask : pulse

  task automatic set_opts(input logic [8:0] o);
    {stopEnableBit, debugModeEnable, lowVoltageEnable, lowVoltageStopEnable,
     partialPowerdownControl, internalRefClockEnable, internalRefStopEnable,
     externalRefClockEnable, externalRefStopEnable} = o;
  endtask : set_opts

  function automatic op_mode_e exp_stop(input logic [8:0] o);
    if (!o[8]) return MODE_RESET;
    return (o[7] || (o[6] && o[5]) || !o[4]) ? MODE_LIGHT_STOP : MODE_DEEP_STOP;
  endfunction : exp_stop

  task automatic bg_back;
    chk_mode(MODE_BACKGROUND);
    chk_bit(cpuSuspended, 1'b1);
    host_u.send(CMD_RESUME, 1'b0);
    chk_mode(MODE_RUN);
  endtask : bg_back

  task automatic end_sim;
    $display("failures=%0d compares=%0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim
  // ------
  // Tests
  // ------
  initial begin
    {clk, rst_n, waitInstr, stopInstr, backgroundInstr, debugCtrlBreak} = '0;
    {debugModuleBreak, irqAny, lightStopWakeIrq, rtcWake, rtcWakeEnable} = '0;
    partialPowerdownAck = 1'b0;
    {modeSelectPin, resetPinLow, powerOnReset, debugForceReset} = 4'hA;
    set_opts(9'h000);
    void'($urandom(38314));
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    chk_mode(MODE_RUN);
    chk_bit(fetchResetVector, 1'b1);
    $display("test reset done");
    pulse(backgroundInstr);
    bg_back();
    pulse(debugCtrlBreak);
    bg_back();
    pulse(debugModuleBreak);
    bg_back();
    for (int i = 0; i < 7; i++) begin
      c = debug_cmd_e'(i);
      host_u.send(c, 1'b1);
      chk_bit(debugCmdAccept, c <= CMD_HALT);
      if (c == CMD_HALT) bg_back();
    end
    host_u.send(CMD_HALT, 1'b0);
    for (int i = 0; i < 6; i++) begin
      host_u.send(debug_cmd_e'(i), 1'b0);
      chk_bit(debugCmdAccept, 1'b1);
    end
    bg_back();
    $display("test debug done");
    pulse(waitInstr);
    chk_mode(MODE_WAIT);
    chk_bit(clearIrqMask, 1'b1);
    chk_bit(cpuClkEn, 1'b0);
    chk_bit(busClkEn, 1'b1);
    for (int i = 0; i < 7; i++) begin
      c = debug_cmd_e'(i);
      if (c != CMD_HALT) host_u.send(c, 1'b1);
      if (c != CMD_HALT) chk_bit(debugCmdStatusErr, c == CMD_MEMORY_STATUS);
      if (c != CMD_HALT) chk_bit(debugCmdAccept, c == CMD_MEMORY_STATUS);
    end
    pulse(irqAny);
    chk_mode(MODE_RUN);
    chk_bit(startStacking, 1'b1);
    pulse(waitInstr);
    host_u.send(CMD_HALT, 1'b0);
    bg_back();
    $display("test wait done");
    for (int i = 0; i < 16; i++) begin
      v = (i < 6) ? corner[i] : 9'($urandom);
      m = exp_stop(v);
      set_opts(v);
      pulse(stopInstr);
      chk_mode(m);
      if (m == MODE_RESET) begin
        chk_bit(illegalOpReset, 1'b1);
        @(negedge clk);
        chk_mode(MODE_RUN);
        continue;
      end
      chk_bit(busClkEn | cpuClkEn | periphClkEn, 1'b0);
      chk_bit(debugClkEn, v[7]);
      chk_bit(regulatorFull, v[7] | (v[6] & v[5]));
      set_opts(~v);
      @(negedge clk);
      chk_mode(m);
      chk_bit(debugClkEn, v[7]);
      if (m == MODE_LIGHT_STOP) begin
        chk_bit(internalRefRun, v[3] & v[2]);
        chk_bit(externalRefRun, v[1] & v[0]);
        host_u.send(CMD_MEMORY_STATUS, 1'b0);
        chk_bit(debugCmdStatusErr, 1'b1);
        host_u.send(CMD_HALT, 1'b0);
        chk_bit(debugCmdAccept, 1'b1);
        chk_mode(v[7] ? MODE_BACKGROUND : MODE_LIGHT_STOP);
        if (v[7]) host_u.send(CMD_CPU_REG, 1'b0);
        if (v[7]) chk_bit(debugCmdAccept, 1'b1);
        if (v[7]) bg_back();
        else pulse(lightStopWakeIrq);
        chk_mode(MODE_RUN);
      end else begin
        chk_bit(pinLatchHold, 1'b1);
        chk_bit(coreDomainPowerOn, 1'b0);
        lightStopWakeIrq = 1'b1;
        pulse(rtcWake);
        lightStopWakeIrq = 1'b0;
        chk_mode(MODE_DEEP_STOP);
        rtcWakeEnable = 1'b1;
        pulse(rtcWake);
        rtcWakeEnable = 1'b0;
        chk_mode(MODE_RESET);
        chk_bit(deepStopPorReset, 1'b1);
        chk_bit(partialPowerdownFlag, 1'b1);
        @(negedge clk);
        chk_mode(MODE_RUN);
        chk_bit(fetchResetVector, 1'b1);
        repeat ($urandom_range(4, 1)) @(negedge clk);
        chk_bit(pinLatchHold & partialPowerdownFlag, 1'b1);
        pulse(partialPowerdownAck);
        chk_bit(partialPowerdownFlag | pinLatchHold, 1'b0);
      end
    end
    $display("test stop done");
    modeSelectPin = 1'b0;
    for (int i = 0; i < 3; i++) begin
      set_opts((i == 2) ? 9'h110 : 9'h100);
      pulse(stopInstr);
      {powerOnReset, debugForceReset} = 2'(i);
      resetPinLow = 1'b1;
      repeat (4) @(negedge clk);
      chk_mode(MODE_RESET);
      resetPinLow = 1'b0;
      repeat (3) @(negedge clk);
      chk_bit(fetchResetVector, 1'b1);
      if (i == 0) chk_mode(MODE_RUN);
      else bg_back();
    end
    chk_bit(partialPowerdownFlag & pinLatchHold, 1'b1);
    pulse(partialPowerdownAck);
    chk_bit(partialPowerdownFlag | pinLatchHold, 1'b0);
    modeSelectPin = 1'b1;
    powerOnReset  = 1'b1;
    $display("test pin reset done");
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
